// file: shared/iag_map.vh
// Purpose: constants for the indexed/indirect operand address generator
// Assumes: 8-bit core, 16-bit byte address space, one-cycle memory read
// Notes:   mode codes are this block's own encoding on the mode input
//
// Contract
// RULE_01: Indexed address is index plus offset, unsigned.
// RULE_02: No-offset indexed: no extra byte, index alone.
// RULE_03: Short indexed: one offset byte, sum to 1FE.
// RULE_04: Long indexed: two offset bytes, full 64K.
// RULE_05: Indirect: pointer address byte, fetch pointer, use.
// RULE_06: Short indirect: one-byte pointer, range 00-FF.
// RULE_07: Long indirect forms fetch two-byte pointer word.
// RULE_08: Indirect indexed: pointer value plus index, unsigned.
// RULE_09: Short indirect indexed: byte pointer plus index.
// RULE_10: Load, compare, logic, arithmetic accept these modes.
// RULE_11: Long sums are truncated to sixteen bits.
`ifndef IAG_MAP_VH
`define IAG_MAP_VH

// ============================================================
// Addressing mode codes
`define IAG_MODE_IDX0      3'h0
`define IAG_MODE_IDX_SHORT 3'h1
`define IAG_MODE_IDX_LONG  3'h2
`define IAG_MODE_IND_SHORT 3'h3
`define IAG_MODE_IND_LONG  3'h4
`define IAG_MODE_IIX_SHORT 3'h5
`define IAG_MODE_IIX_LONG  3'h6

// ============================================================
// Operation codes accepted with these modes
`define IAG_OP_LOAD        4'h0
`define IAG_OP_COMPARE     4'h1
`define IAG_OP_BIT_COMPARE 4'h2
`define IAG_OP_AND         4'h3
`define IAG_OP_OR          4'h4
`define IAG_OP_XOR         4'h5
`define IAG_OP_ADD         4'h6
`define IAG_OP_ADC         4'h7
`define IAG_OP_SUB         4'h8
`define IAG_OP_SBC         4'h9

// ============================================================
// Widths
`define IAG_AW 16
`define IAG_DW 8

`endif

// file: src/iag_addr_gen.v
// Purpose: operand address generation for indexed and indirect modes
// Assumes: memory returns rd_data combinationally while rd_en_r is high,
//          so each byte is taken at the edge that ends its read cycle
// Notes:   opcode is consumed by the decoder; pc points past it at start
//          pointer addresses live in page zero; the low byte of a word
//          pointer may sit at 0100, the pointer address is not wrapped
//          short sums keep their ninth bit, long sums wrap at 16 bits
`timescale 1ns/1ps
`include "iag_map.vh"

module iag_addr_gen (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        reset_n,
    // Request from decoder
    input  wire        start,
    input  wire [2:0]  mode,
    input  wire [3:0]  op,
    input  wire        use_y,
    input  wire [7:0]  x_reg,
    input  wire [7:0]  y_reg,
    input  wire [15:0] pc,
    // Memory read port
    output reg         rd_en_r,
    output reg  [15:0] rd_addr_r,
    input  wire [7:0]  rd_data,
    // Result
    output reg         busy_r,
    output reg         done_r,
    output reg         illegal_r,
    output reg  [15:0] ea_r,
    output reg  [1:0]  ext_bytes_r
);

    // ========================================================
    // States
    localparam ST_IDLE = 3'h0;
    localparam ST_OPH  = 3'h1;  // first byte after opcode
    localparam ST_OPL  = 3'h2;  // second byte of long offset
    localparam ST_PTH  = 3'h3;  // pointer byte / high byte
    localparam ST_PTL  = 3'h4;  // pointer low byte
    localparam ST_CALC = 3'h5;

    reg [2:0]  state_r;
    reg [2:0]  mode_r;
    reg [7:0]  idx_r;
    reg [15:0] pc_r;
    reg [7:0]  paddr_r;
    reg        pclr;
    reg        ld_hi;
    reg        ld_lo;
    wire [15:0] word;

    // Operation check: only the ten listed ops take these modes
    function op_ok;
        input [3:0] o;
        begin
            op_ok = (o <= `IAG_OP_SBC);                   // [RULE_10]
        end
    endfunction

    // Index register picked by the decoder's select bit
    function [7:0] sel_idx;
        input       sel;
        input [7:0] xv;
        input [7:0] yv;
        begin
            sel_idx = sel ? yv : xv;
        end
    endfunction

    // Mode is long (word offset or word pointer)
    function is_long;
        input [2:0] m;
        begin
            is_long = (m == `IAG_MODE_IDX_LONG) ||
                      (m == `IAG_MODE_IND_LONG) ||
                      (m == `IAG_MODE_IIX_LONG);
        end
    endfunction

    // Holding word for offset or pointer bytes
    iag_ptr_reg u_word (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .clr     (pclr),
        .ld_hi   (ld_hi),
        .ld_lo   (ld_lo),
        .din     (rd_data),
        .word_r  (word)
    );

    // ========================================================
    // Byte strobes into the holding word; they follow the state so that
    // the byte on rd_data is captured at the edge the sequencer moves on.
    // Short forms fill only the low byte, the high byte stays zero.
    always @* begin
        pclr  = 1'b0;
        ld_hi = 1'b0;
        ld_lo = 1'b0;
        case (state_r)
            ST_IDLE: pclr = start;
            ST_OPH: begin
                if (mode_r == `IAG_MODE_IDX_LONG) begin
                    ld_hi = 1'b1;                         // [RULE_04]
                end else if (mode_r == `IAG_MODE_IDX_SHORT) begin
                    ld_lo = 1'b1;                         // [RULE_03]
                end
            end
            ST_OPL: ld_lo = 1'b1;
            ST_PTH: begin
                if (is_long(mode_r)) begin
                    ld_hi = 1'b1;                         // [RULE_07]
                end else begin
                    ld_lo = 1'b1;                         // [RULE_06]
                end
            end
            ST_PTL: ld_lo = 1'b1;
            default: ;
        endcase
    end

    // ========================================================
    // Sequencer; each fetch issues a registered read and takes the byte
    // at the next edge, so a fetch costs one cycle and no wait state.
    // Start is only looked at in idle, which is how busy refuses it.
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r     <= ST_IDLE;
            mode_r      <= 3'h0;
            idx_r       <= 8'h00;
            pc_r        <= 16'h0000;
            paddr_r     <= 8'h00;
            rd_en_r     <= 1'b0;
            rd_addr_r   <= 16'h0000;
            busy_r      <= 1'b0;
            done_r      <= 1'b0;
            illegal_r   <= 1'b0;
            ea_r        <= 16'h0000;
            ext_bytes_r <= 2'h0;
        end else begin
            done_r    <= 1'b0;
            illegal_r <= 1'b0;
            rd_en_r   <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (start) begin
                        if (!op_ok(op) || mode > `IAG_MODE_IIX_LONG) begin
                            // Refused: no read, no state change
                            illegal_r <= 1'b1;
                        end else begin
                            mode_r <= mode;
                            idx_r  <= sel_idx(use_y, x_reg, y_reg);
                            pc_r   <= pc;
                            busy_r <= 1'b1;
                            if (mode == `IAG_MODE_IDX0) begin
                                // No byte fetched; index alone
                                ea_r        <= {8'h00,
                                                sel_idx(use_y, x_reg, y_reg)};
                                ext_bytes_r <= 2'h0;     // [RULE_02]
                                state_r     <= ST_CALC;
                            end else begin
                                rd_en_r     <= 1'b1;
                                rd_addr_r   <= pc;
                                ext_bytes_r <= (mode == `IAG_MODE_IDX_LONG)
                                               ? 2'h2 : 2'h1;
                                state_r     <= ST_OPH;
                            end
                        end
                    end
                end
                ST_OPH: begin
                    if (mode_r == `IAG_MODE_IDX_LONG) begin
                        rd_en_r   <= 1'b1;
                        rd_addr_r <= pc_r + 16'h0001;
                        state_r   <= ST_OPL;
                    end else if (mode_r == `IAG_MODE_IDX_SHORT) begin
                        state_r <= ST_CALC;
                    end else begin
                        // Byte after opcode is the pointer address
                        paddr_r   <= rd_data;                 // [RULE_05]
                        rd_en_r   <= 1'b1;
                        rd_addr_r <= {8'h00, rd_data};
                        state_r   <= ST_PTH;
                    end
                end
                ST_OPL: state_r <= ST_CALC;
                ST_PTH: begin
                    if (is_long(mode_r)) begin
                        // Pointer word high byte first, low at next address
                        rd_en_r   <= 1'b1;
                        rd_addr_r <= {8'h00, paddr_r} + 16'h0001;
                        state_r   <= ST_PTL;
                    end else begin
                        state_r <= ST_CALC;
                    end
                end
                ST_PTL: state_r <= ST_CALC;
                ST_CALC: begin
                    // Sum from the held word; a cycle of its own keeps
                    // the adder off the memory read path
                    case (mode_r)
                        `IAG_MODE_IDX0: ;
                        `IAG_MODE_IDX_SHORT, `IAG_MODE_IIX_SHORT:
                            // 8+8 bit sum, at most 1fe
                            ea_r <= {8'h00, word[7:0]} +
                                    {8'h00, idx_r};   // [RULE_03] [RULE_09]
                        `IAG_MODE_IDX_LONG, `IAG_MODE_IIX_LONG:
                            // Carry out of bit 15 dropped on purpose
                            ea_r <= word + {8'h00, idx_r}; // [RULE_11]
                        default:
                            ea_r <= word;             // [RULE_06] [RULE_07]
                    endcase
                    done_r  <= 1'b1;                  // [RULE_01] [RULE_08]
                    busy_r  <= 1'b0;
                    state_r <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

endmodule

// file: src/iag_ptr_reg.v
// Purpose: two-byte holding register for offset or pointer bytes
// Assumes: bytes arrive high first, one load strobe each
// Notes:   read value comes from flip-flops
`timescale 1ns/1ps

module iag_ptr_reg (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        reset_n,
    // Control
    input  wire        clr,
    input  wire        ld_hi,
    input  wire        ld_lo,
    input  wire [7:0]  din,
    // Held word
    output reg  [15:0] word_r
);

    // ========================================================
    // Byte capture; clear wins so a fresh instruction starts at zero
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            word_r <= 16'h0000;
        end else if (clr) begin
            word_r <= 16'h0000;
        end else begin
            if (ld_hi) begin
                word_r[15:8] <= din;
            end
            if (ld_lo) begin
                word_r[7:0] <= din;
            end
        end
    end

endmodule

// file: test/iag_addr_gen_props.sv
// Purpose: port timing checks for the address generator
// Assumes: one clock, memory answers within the read cycle
// Notes:   bound into iag_addr_gen below
`timescale 1ns/1ps
module iag_chk (
    // Clock, reset and request
    input wire        ref_clk,
    input wire        reset_n,
    input wire        start,
    input wire [2:0]  mode,
    input wire [3:0]  op,
    input wire        use_y,
    input wire [7:0]  x_reg,
    input wire [7:0]  y_reg,
    input wire [15:0] pc,
    // Memory port and result
    input wire        rd_en_r,
    input wire [15:0] rd_addr_r,
    input wire [7:0]  rd_data,
    input wire        busy_r,
    input wire        done_r,
    input wire        illegal_r,
    input wire [15:0] ea_r,
    input wire [1:0]  ext_bytes_r
);
    // ==========================================================
    // Helpers: taken request, legal codes, chosen index
    wire       go  = start && !busy_r;
    wire       ok  = op <= 4'h9 && mode != 3'h7;
    wire [7:0] ix  = use_y ? y_reg : x_reg;
    wire [1:0] ext = mode == 3'h0 ? 2'h0 : mode == 3'h2 ? 2'h2 : 2'h1;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // Read steps: byte after opcode, zero-page pointer, next byte
    sequence s_pc;
        rd_en_r && rd_addr_r == $past(pc);
    endsequence
    sequence s_ptr;
        rd_en_r && rd_addr_r == {8'h00, $past(rd_data)};
    endsequence
    sequence s_next;
        rd_en_r && rd_addr_r == $past(rd_addr_r) + 16'h1;
    endsequence
    // ==========================================================
    // Assertions
    chk_bad_refused: assert property (
        go && !ok |=> illegal_r && !rd_en_r)
        else $error("bad request was not refused");
    chk_good_taken: assert property (
        go && ok |=> busy_r && !illegal_r && ext_bytes_r == $past(ext))
        else $error("legal request not taken");
    chk_idx0_direct: assert property (
        go && ok && mode == 3'h0 |=> !rd_en_r ##1
            done_r && ea_r == {8'h00, $past(ix, 2)})
        else $error("no-offset address is not the index");
    chk_short_sum: assert property (
        go && ok && mode == 3'h1 |=> s_pc ##2
            done_r && ea_r == $past(ix, 3) + $past(rd_data, 2))
        else $error("short indexed sum wrong");
    chk_long_wrap: assert property (
        go && ok && mode == 3'h2 |=> s_pc ##1 s_next ##2 done_r &&
            ea_r == {$past(rd_data, 3), $past(rd_data, 2)} + $past(ix, 4))
        else $error("long indexed sum wrong");
    chk_ind_pointer: assert property (
        go && ok && mode == 3'h3 |=> s_pc ##1 s_ptr ##2
            done_r && ea_r == {8'h00, $past(rd_data, 2)})
        else $error("short indirect pointer not used");
    chk_iix_sum: assert property (
        go && ok && mode == 3'h5 |=> s_pc ##1 s_ptr ##2
            done_r && ea_r == $past(rd_data, 2) + $past(ix, 4))
        else $error("short indirect indexed sum wrong");
    chk_ind_word: assert property (
        go && ok && mode == 3'h4 |=> s_pc ##1 s_ptr ##1 s_next ##2
            done_r && ea_r == {$past(rd_data, 3), $past(rd_data, 2)})
        else $error("long indirect pointer word not used");
    chk_iix_wrap: assert property (
        go && ok && mode == 3'h6 |=> s_pc ##1 s_ptr ##1 s_next ##2
            done_r && ea_r == {$past(rd_data, 3), $past(rd_data, 2)} +
            $past(ix, 5))
        else $error("long indirect indexed sum wrong");
    chk_read_in_busy: assert property (
        rd_en_r |-> busy_r)
        else $error("read issued while idle");
endmodule

bind iag_addr_gen iag_chk iag_chk_i (.ref_clk, .reset_n, .start, .mode,
    .op, .use_y, .x_reg, .y_reg, .pc, .rd_en_r, .rd_addr_r, .rd_data,
    .busy_r, .done_r, .illegal_r, .ea_r, .ext_bytes_r);

// file: test/iag_mem_model.sv
// Purpose: core memory seen by the address generator
// Assumes: read data follows rd_addr within the cycle rd_en is high
// Notes:   byte at a is a[7:0] ^ a[15:8] ^ a5
`timescale 1ns/1ps
module iag_mem_model (
    // Read port
    input  wire        rd_en,
    input  wire [15:0] rd_addr,
    output reg  [7:0]  rd_data
);
    // Outside a read the bus shows the inverse, so stale bytes cannot pass
    always @* begin
        if (rd_en)
            rd_data = rd_addr[7:0] ^ rd_addr[15:8] ^ 8'ha5;
        else
            rd_data = ~(rd_addr[7:0] ^ rd_addr[15:8] ^ 8'ha5);
    end
endmodule

// file: test/tb_indexed_indirect_address_gen.sv
// Purpose: self-checking bench for the address generator
// Assumes: memory model map a[7:0] ^ a[15:8] ^ a5
// Notes:   x index ff and y index 03 unless a test changes them
`timescale 1ns/1ps
module tb_indexed_indirect_address_gen;
    reg         ref_clk, reset_n, start, use_y;
    reg  [2:0]  mode;
    reg  [3:0]  op;
    reg  [7:0]  x_reg, y_reg;
    reg  [15:0] pc;
    wire        rd_en_r, busy_r, done_r, illegal_r;
    wire [15:0] rd_addr_r, ea_r;
    wire [7:0]  rd_data;
    wire [1:0]  ext_bytes_r;
    integer     errors, checked, i;

    // ==========================================================
    // Design and memory
    iag_addr_gen iag_addr_gen_i (.ref_clk, .reset_n, .start, .mode, .op,
        .use_y, .x_reg, .y_reg, .pc, .rd_en_r, .rd_addr_r, .rd_data,
        .busy_r, .done_r, .illegal_r, .ea_r, .ext_bytes_r);
    iag_mem_model iag_mem_model_i (.rd_en(rd_en_r), .rd_addr(rd_addr_r),
        .rd_data);

    // ==========================================================
    // Shared tasks
    task check(input [63:0] nm, input [15:0] seen, input [15:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("wrong value %0s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task report_and_stop;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // One request; answer awaited under a bound, reads counted
    task xfer(input [2:0] m, input [3:0] o, input uy, input [15:0] p,
              input [15:0] eea, input [1:0] eext, input [1:0] erd,
              input eill);
        integer n;
        integer nrd;
        @(posedge ref_clk);
        start <= 1'b1;
        mode <= m;
        op <= o;
        use_y <= uy;
        pc <= p;
        @(posedge ref_clk);
        start <= 1'b0;
        #1;
        n = 0;
        nrd = 0;
        while (done_r !== 1'b1 && illegal_r !== 1'b1 && n < 20) begin
            nrd = nrd + rd_en_r;
            @(posedge ref_clk);
            #1;
            n = n + 1;
        end
        if (n == 20) begin
            errors = errors + 1;
            report_and_stop;
        end
        check("illegal", illegal_r, eill);
        check("reads", nrd, erd);
        if (!eill) begin
            check("ea", ea_r, eea);
            check("ext", ext_bytes_r, eext);
        end
    endtask

    // ==========================================================
    // Scenarios
    task t_idx;
        xfer(3'h0, 4'h0, 0, 16'h0200, 16'h00ff, 0, 0, 0);
        xfer(3'h1, 4'h1, 0, 16'h005a, 16'h01fe, 1, 1, 0);
        xfer(3'h1, 4'h2, 1, 16'h005a, 16'h0102, 1, 1, 0);
        xfer(3'h2, 4'h3, 1, 16'h005a, 16'h0001, 2, 2, 0);
        $display("indexed test done");
    endtask
    task t_ind;
        xfer(3'h3, 4'h4, 0, 16'h0010, 16'h0010, 1, 2, 0);
        xfer(3'h4, 4'h5, 0, 16'h0010, 16'h1013, 1, 3, 0);
        $display("indirect test done");
    endtask
    // Pointer fffe plus ff must wrap to 00fd
    task t_iix;
        xfer(3'h5, 4'h6, 0, 16'h00ff, 16'h01fe, 1, 2, 0);
        xfer(3'h6, 4'h7, 0, 16'h00ff, 16'h00fd, 1, 3, 0);
        $display("indirect indexed test done");
    endtask
    // Every code in one form, short indexed if even and long indexed if odd; spare codes refused
    task t_ops;
        for (i = 0; i < 16; i = i + 1) begin
            xfer({1'b0, i[0], ~i[0]}, i[3:0], 1, 16'h005a,
                 i[0] ? 16'h0001 : 16'h0102, {i[0], ~i[0]},
                 i > 9 ? 2'h0 : {i[0], ~i[0]}, i > 9);
        end
        xfer(3'h7, 4'h0, 0, 16'h0010, 16'h0000, 0, 0, 1);
        $display("operation test done");
    endtask

    // ==========================================================
    // Clock at 125 MHz
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // Reset for three cycles, then the tests in turn
    initial begin
        errors = 0;
        checked = 0;
        reset_n = 1'b0;
        start = 1'b0;
        use_y = 1'b0;
        mode = 3'h0;
        op = 4'h0;
        x_reg = 8'hff;
        y_reg = 8'h03;
        pc = 16'h0000;
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_idx;
        t_ind;
        t_iix;
        t_ops;
        report_and_stop;
    end
endmodule
